// ==== hw/bse_defs.svh ====
// Constants for the boot serial info and erase exchange
`ifndef BSE_DEFS_SVH
`define BSE_DEFS_SVH

// Session and command codes
`define BSE_MODE_ASYNC 8'h86
`define BSE_MODE_CLOCKED 8'h30
`define BSE_CMD_ERASE 8'h40
`define BSE_CMD_INFO 8'h30
`define BSE_CONF_ERASE 8'h54
`define BSE_RES_OK 8'h4f
`define BSE_RES_FAIL 8'h4c
`define BSE_NAK_NIB 4'h1
`define BSE_ERR_NIB 4'h8

// Product information reply byte numbering
`define BSE_INFO_FIRST 7'h05
`define BSE_INFO_LAST_DATA 7'h5c
`define BSE_INFO_SUM 7'h5d

// Memory layout words, large and small variants
`define BSE_PWD_L 32'h3f87ff04
`define BSE_PWD_S 32'h3f81ff04
`define BSE_RAM_START 32'h20000000
`define BSE_RAM_END_L 32'h20007fff
`define BSE_RAM_END_S 32'h20001fff
`define BSE_FL_START 32'h3f800000
`define BSE_FL_END_L 32'h3f87ffff
`define BSE_FL_END_S 32'h3f81ffff
`define BSE_FL_CNT_L 32'h00000006
`define BSE_FL_CNT_S 32'h00000004
`define BSE_G16_START_L 32'h00000000
`define BSE_G16_START_S 32'h3f800000
`define BSE_G16_SIZE 32'h00002000
`define BSE_G16_N_L 32'h00000000
`define BSE_G16_N_S 32'h00000002
`define BSE_G32_START_L 32'h3f800000
`define BSE_G32_START_S 32'h3f808000
`define BSE_G32_SIZE 32'h00004000
`define BSE_G32_N_L 32'h00000002
`define BSE_G32_N_S 32'h00000001
`define BSE_G64_START 32'h3f810000
`define BSE_G64_SIZE 32'h00008000
`define BSE_G64_N 32'h00000001
`define BSE_G128_START_L 32'h3f820000
`define BSE_G128_START_S 32'h00000000
`define BSE_G128_SIZE 32'h00010000
`define BSE_G128_N_L 32'h00000003
`define BSE_G128_N_S 32'h00000000

// Host wait for the mode echo
`define BSE_CLK_MHZ 250
`define BSE_ECHO_TIMEOUT_S 5
`define BSE_ECHO_TIMEOUT_CYC (64'd`BSE_ECHO_TIMEOUT_S * 64'd`BSE_CLK_MHZ * 64'd1000000)

`endif

// ==== hw/bse_pkg.sv ====
// Types shared by both ends of the boot serial exchange
package bse_pkg;
	typedef enum {
		BSE_D_MODE,
		BSE_D_WAIT_CMD,
		BSE_D_WAIT_CONF,
		BSE_D_ERASE,
		BSE_D_INFO,
		BSE_D_DEAD
	} bse_dev_state_e;

	typedef enum {
		BSE_H_IDLE,
		BSE_H_SEND_MODE,
		BSE_H_GET_ECHO,
		BSE_H_SEND_CMD,
		BSE_H_GET_ACK,
		BSE_H_SEND_CONF,
		BSE_H_GET_CACK,
		BSE_H_GET_RESULT,
		BSE_H_GET_INFO
	} bse_host_state_e;

	typedef logic [7:0] bse_byte_t;
endpackage : bse_pkg

// ==== hw/bse_link_if.sv ====
// Byte-level serial link between programming host and device
`timescale 1ns/10ps
`default_nettype none
interface bse_link_if (
	input wire logic sys_clk
);
	// Host to device
	logic h2d_valid;
	bse_pkg::bse_byte_t h2d_data;
	logic h2d_err;
	logic h2d_slow;
	logic h2d_ready;
	// Device to host
	logic d2h_valid;
	bse_pkg::bse_byte_t d2h_data;
	logic d2h_ready;

	modport dev (
		input h2d_valid, h2d_data, h2d_err, h2d_slow, d2h_ready,
		output h2d_ready, d2h_valid, d2h_data
	);
	modport host (
		output h2d_valid, h2d_data, h2d_err, h2d_slow, d2h_ready,
		input h2d_ready, d2h_valid, d2h_data
	);
endinterface : bse_link_if
`default_nettype wire

// ==== hw/bse_fifo.sv ====
// Two-entry byte buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module bse_fifo (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Fill side
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [7:0] out_data,
	input wire logic out_ready
);
	logic [7:0] mem [2];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data = mem[rd_ptr];

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= ~wr_ptr;
			end
			if (pop)
				rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : bse_fifo
`default_nettype wire

// ==== hw/bse_device.sv ====
// Device end: mode echo, product information reply and chip erase
`include "bse_defs.svh"
`timescale 1ns/10ps
`default_nettype none
// Function
// R1 - Byte 83 reports one 64K block
// R2 - Bytes 84-87: 128K group start, LSB first
// R3 - Bytes 88-91: 128K block halfword size
// R4 - Byte 92: 128K block count per variant
// R5 - Byte 93 is checksum of bytes 5-92
// R6 - Checksum makes byte sum zero modulo 256
// R7 - After exchange, wait for next command
// R8 - Host sends first two bytes slowly; host sets h2d_slow for mode byte and echo in clocked sessions only
// R9 - Any negative acknowledge returns to command wait
// R10 - No error acknowledge in clocked mode
// R11 - Host opens with 0x86 or 0x30
// R12 - Echo mode byte, abort silently on bad rate
// R13 - 0x40 erase request, ack or nibble-1 reject
// R14 - Receive error answers low nibble 8
// R15 - Host confirms erase with 0x54
// R16 - Confirm acked 0x54, else nak or error
// R17 - Erase result 0x4f success, 0x4c failure
// R18 - Erase clears all, sets security bit
// R19 - Error ack upper nibble repeats last command
module bse_device #(
	parameter logic SMALL_VARIANT = 1'b0,
	// Product name bytes; value is arbitrary
	parameter logic [95:0] PRODUCT_NAME = 96'h3130_4543_4956_4544_544f_4f42
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Link to the host
	bse_link_if.dev link,
	// Device environment
	input wire logic rate_ok,
	input wire logic [31:0] flash_id,
	// Flash erase engine
	output logic erase_start,
	input wire logic erase_done,
	input wire logic erase_ok,
	output logic sec_bit
);
	function automatic logic [7:0] bse_info_byte(input logic [6:0] idx,
		input logic tiny, input logic [31:0] fid);
		logic [31:0] w;
		logic [6:0] base;
		logic [1:0] off;
		w = 32'h0;
		base = idx;
		if (idx >= 7'd9 && idx < 7'd21)
			return PRODUCT_NAME[8 * (7'(idx - 7'd9)) +: 8];
		if (idx < 7'd9) begin
			w = fid;
			base = 7'd5;
		end else if (idx < 7'd25) begin
			w = tiny ? `BSE_PWD_S : `BSE_PWD_L;
			base = 7'd21;
		end else if (idx < 7'd29) begin
			w = `BSE_RAM_START;
			base = 7'd25;
		end else if (idx < 7'd33) begin
			base = 7'd29;
		end else if (idx < 7'd37) begin
			w = tiny ? `BSE_RAM_END_S : `BSE_RAM_END_L;
			base = 7'd33;
		end else if (idx < 7'd47) begin
			base = 7'd45;
			w = 32'h0;
		end else if (idx < 7'd51) begin
			w = `BSE_FL_START;
			base = 7'd47;
		end else if (idx < 7'd55) begin
			w = tiny ? `BSE_FL_END_S : `BSE_FL_END_L;
			base = 7'd51;
		end else if (idx < 7'd57) begin
			w = tiny ? `BSE_FL_CNT_S : `BSE_FL_CNT_L;
			base = 7'd55;
		end else if (idx < 7'd61) begin
			w = tiny ? `BSE_G16_START_S : `BSE_G16_START_L;
			base = 7'd57;
		end else if (idx < 7'd65) begin
			w = `BSE_G16_SIZE;
			base = 7'd61;
		end else if (idx < 7'd66) begin
			w = tiny ? `BSE_G16_N_S : `BSE_G16_N_L;
		end else if (idx < 7'd70) begin
			w = tiny ? `BSE_G32_START_S : `BSE_G32_START_L;
			base = 7'd66;
		end else if (idx < 7'd74) begin
			w = `BSE_G32_SIZE;
			base = 7'd70;
		end else if (idx < 7'd75) begin
			w = tiny ? `BSE_G32_N_S : `BSE_G32_N_L;
		end else if (idx < 7'd79) begin
			w = `BSE_G64_START;
			base = 7'd75;
		end else if (idx < 7'd83) begin
			w = `BSE_G64_SIZE;
			base = 7'd79;
		end else if (idx < 7'd84) begin
			w = `BSE_G64_N; // [R1]
		end else if (idx < 7'd88) begin
			w = tiny ? `BSE_G128_START_S : `BSE_G128_START_L; // [R2]
			base = 7'd84;
		end else if (idx < 7'd92) begin
			w = `BSE_G128_SIZE; // [R3]
			base = 7'd88;
		end else begin
			w = tiny ? `BSE_G128_N_S : `BSE_G128_N_L; // [R4]
		end
		// Multi-byte words go out least significant byte first
		off = 2'(idx - base);
		return w[8 * off +: 8];
	endfunction : bse_info_byte

	bse_pkg::bse_dev_state_e state, next_state;
	logic clocked, next_clocked;
	logic tx_pend, next_pend;
	logic [7:0] tx_hold, next_hold;
	logic [7:0] last_cmd, next_last_cmd;
	logic [6:0] idx, next_idx;
	logic [7:0] sum, next_sum;
	logic rx_ready, next_rx_ready;
	logic next_erase_start;
	logic next_sec_bit;
	logic fifo_in_ready;

	wire rx_take = link.h2d_valid && rx_ready;
	wire [7:0] rx_byte = link.h2d_data;
	// Clocked mode never reports reception errors
	wire rx_bad = link.h2d_err && !clocked; // [R10]
	wire [7:0] err_ack = {last_cmd[7:4], `BSE_ERR_NIB}; // [R14] [R19]
	wire [7:0] nak = {rx_byte[7:4], `BSE_NAK_NIB};
	wire [7:0] info_now = bse_info_byte(idx, SMALL_VARIANT, flash_id);
	wire [7:0] sum_byte = 8'(~sum + 8'h01); // [R5] [R6]

	assign link.h2d_ready = rx_ready;

	always_comb begin
		next_state = state;
		next_clocked = clocked;
		next_pend = tx_pend;
		next_hold = tx_hold;
		next_last_cmd = last_cmd;
		next_idx = idx;
		next_sum = sum;
		next_erase_start = 1'b0;
		next_sec_bit = sec_bit;
		if (tx_pend && fifo_in_ready)
			next_pend = 1'b0;
		unique case (state)
			bse_pkg::BSE_D_MODE: begin
				if (rx_take && rx_byte == `BSE_MODE_ASYNC) begin
					// Unusable rate: stop without a word
					if (rate_ok) begin // [R12]
						next_pend = 1'b1;
						next_hold = rx_byte;
						next_clocked = 1'b0;
						next_state = bse_pkg::BSE_D_WAIT_CMD;
					end else begin
						next_state = bse_pkg::BSE_D_DEAD;
					end
				end else if (rx_take && rx_byte == `BSE_MODE_CLOCKED) begin
					next_pend = 1'b1;
					next_hold = rx_byte; // [R12]
					next_clocked = 1'b1;
					next_state = bse_pkg::BSE_D_WAIT_CMD;
				end
			end
			bse_pkg::BSE_D_WAIT_CMD: begin
				if (rx_take) begin
					next_pend = 1'b1;
					if (rx_bad) begin
						next_hold = err_ack; // [R14]
					end else if (rx_byte == `BSE_CMD_ERASE) begin
						next_hold = rx_byte; // [R13]
						next_last_cmd = rx_byte;
						next_state = bse_pkg::BSE_D_WAIT_CONF;
					end else if (rx_byte == `BSE_CMD_INFO) begin
						next_hold = rx_byte;
						next_last_cmd = rx_byte;
						next_idx = `BSE_INFO_FIRST;
						next_sum = 8'h00;
						next_state = bse_pkg::BSE_D_INFO;
					end else begin
						next_hold = nak; // [R13] [R9]
						next_last_cmd = rx_byte;
					end
				end
			end
			bse_pkg::BSE_D_WAIT_CONF: begin
				if (rx_take) begin
					next_pend = 1'b1;
					next_state = bse_pkg::BSE_D_WAIT_CMD; // [R9]
					if (rx_bad) begin
						next_hold = err_ack; // [R16]
					end else if (rx_byte == `BSE_CONF_ERASE) begin
						next_hold = rx_byte; // [R16]
						next_last_cmd = rx_byte;
						next_erase_start = 1'b1;
						next_state = bse_pkg::BSE_D_ERASE;
					end else begin
						next_hold = nak; // [R16]
						next_last_cmd = rx_byte;
					end
				end
			end
			bse_pkg::BSE_D_ERASE: begin
				// The engine wipes every block and its protection
				if (erase_done && !tx_pend) begin // [R18]
					next_pend = 1'b1;
					next_hold = erase_ok ? `BSE_RES_OK : `BSE_RES_FAIL; // [R17]
					if (erase_ok)
						next_sec_bit = 1'b1; // [R18]
					next_state = bse_pkg::BSE_D_WAIT_CMD; // [R7]
				end
			end
			bse_pkg::BSE_D_INFO: begin
				if (!tx_pend) begin
					next_pend = 1'b1;
					next_idx = 7'(idx + 7'd1);
					if (idx == `BSE_INFO_SUM) begin
						next_hold = sum_byte; // [R5]
						next_state = bse_pkg::BSE_D_WAIT_CMD; // [R7]
					end else begin
						next_hold = info_now;
						next_sum = 8'(sum + info_now); // [R6]
					end
				end
			end
			bse_pkg::BSE_D_DEAD: begin
				next_state = bse_pkg::BSE_D_DEAD;
			end
		endcase
		// Reception reopens only once the answer sits in the buffer
		next_rx_ready = !next_pend && !next_erase_start &&
			(next_state == bse_pkg::BSE_D_MODE ||
			next_state == bse_pkg::BSE_D_WAIT_CMD ||
			next_state == bse_pkg::BSE_D_WAIT_CONF);
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state <= bse_pkg::BSE_D_MODE;
			clocked <= 1'b0;
			tx_pend <= 1'b0;
			tx_hold <= 8'h00;
			last_cmd <= 8'h00;
			idx <= 7'h00;
			sum <= 8'h00;
			rx_ready <= 1'b0;
			erase_start <= 1'b0;
			sec_bit <= 1'b0;
		end else begin
			state <= next_state;
			clocked <= next_clocked;
			tx_pend <= next_pend;
			tx_hold <= next_hold;
			last_cmd <= next_last_cmd;
			idx <= next_idx;
			sum <= next_sum;
			rx_ready <= next_rx_ready;
			erase_start <= next_erase_start;
			sec_bit <= next_sec_bit;
		end
	end

	// Buffer lets the host stall without losing a reply byte
	bse_fifo u_tx_fifo (
		.sys_clk(sys_clk),
		.reset(reset),
		.in_valid(tx_pend),
		.in_data(tx_hold),
		.in_ready(fifo_in_ready),
		.out_valid(link.d2h_valid),
		.out_data(link.d2h_data),
		.out_ready(link.d2h_ready)
	);
endmodule : bse_device
`default_nettype wire

// ==== hw/bse_host.sv ====
// Host end: opens a session and runs erase or product information
`include "bse_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module bse_host #(
	parameter logic [63:0] ECHO_TIMEOUT_CYC = `BSE_ECHO_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Link to the device
	bse_link_if.host link,
	// Command request
	input wire logic start,
	input wire logic op_info,
	input wire logic use_clocked,
	input wire logic inject_err,
	// Outcome
	output logic busy,
	output logic done,
	output logic ok,
	output logic [7:0] result,
	output logic info_valid,
	output logic [7:0] info_data
);
	bse_pkg::bse_host_state_e state, next_state;
	logic linked, next_linked;
	logic clocked, next_clocked;
	logic is_info, next_is_info;
	logic [63:0] wait_cnt, next_wait_cnt;
	logic [6:0] cnt, next_cnt;
	logic [7:0] sum, next_sum;
	logic tx_valid, next_tx_valid;
	logic [7:0] tx_data, next_tx_data;
	logic tx_err, next_tx_err;
	logic next_done, next_ok, next_info_valid;
	logic [7:0] next_result, next_info_data;

	wire rx_ready = (state == bse_pkg::BSE_H_GET_ECHO ||
		state == bse_pkg::BSE_H_GET_ACK ||
		state == bse_pkg::BSE_H_GET_CACK ||
		state == bse_pkg::BSE_H_GET_RESULT ||
		state == bse_pkg::BSE_H_GET_INFO);
	wire rx_take = link.d2h_valid && link.d2h_ready;
	wire [7:0] rx = link.d2h_data;
	wire tx_done = tx_valid && link.h2d_ready;
	wire [7:0] mode_code = clocked ? `BSE_MODE_CLOCKED : `BSE_MODE_ASYNC;
	wire [7:0] cmd_code = is_info ? `BSE_CMD_INFO : `BSE_CMD_ERASE;

	always_comb begin
		next_state = state;
		next_linked = linked;
		next_clocked = clocked;
		next_is_info = is_info;
		next_wait_cnt = wait_cnt;
		next_cnt = cnt;
		next_sum = sum;
		next_tx_valid = tx_valid && !tx_done;
		next_tx_data = tx_data;
		next_tx_err = tx_err;
		next_done = 1'b0;
		next_ok = ok;
		next_result = result;
		next_info_valid = 1'b0;
		next_info_data = info_data;
		unique case (state)
			bse_pkg::BSE_H_IDLE: begin
				if (start) begin
					next_is_info = op_info;
					next_tx_valid = 1'b1;
					next_tx_err = inject_err;
					// An open session skips the mode byte
					if (linked) begin // [R7]
						next_tx_data = op_info ? `BSE_CMD_INFO : `BSE_CMD_ERASE;
						next_state = bse_pkg::BSE_H_SEND_CMD;
					end else begin
						next_clocked = use_clocked;
						next_tx_data = use_clocked ? `BSE_MODE_CLOCKED :
							`BSE_MODE_ASYNC; // [R11]
						next_tx_err = 1'b0;
						next_state = bse_pkg::BSE_H_SEND_MODE;
					end
				end
			end
			bse_pkg::BSE_H_SEND_MODE: begin
				if (tx_done) begin
					next_wait_cnt = 64'h0;
					next_state = bse_pkg::BSE_H_GET_ECHO;
				end
			end
			bse_pkg::BSE_H_GET_ECHO: begin
				next_wait_cnt = wait_cnt + 64'h1;
				if (rx_take && rx == mode_code) begin
					next_linked = 1'b1;
					next_tx_valid = 1'b1;
					next_tx_data = cmd_code;
					next_tx_err = inject_err;
					next_state = bse_pkg::BSE_H_SEND_CMD;
				end else if (rx_take || wait_cnt >= ECHO_TIMEOUT_CYC) begin
					next_done = 1'b1;
					next_ok = 1'b0;
					next_result = rx_take ? rx : 8'h00;
					next_state = bse_pkg::BSE_H_IDLE;
				end
			end
			bse_pkg::BSE_H_SEND_CMD: begin
				if (tx_done)
					next_state = bse_pkg::BSE_H_GET_ACK;
			end
			bse_pkg::BSE_H_GET_ACK: begin
				if (rx_take) begin
					next_result = rx;
					if (rx == cmd_code && is_info) begin
						next_cnt = `BSE_INFO_FIRST;
						next_sum = 8'h00;
						next_state = bse_pkg::BSE_H_GET_INFO;
					end else if (rx == cmd_code) begin
						next_tx_valid = 1'b1;
						next_tx_data = `BSE_CONF_ERASE; // [R15]
						next_tx_err = 1'b0;
						next_state = bse_pkg::BSE_H_SEND_CONF;
					end else begin
						next_done = 1'b1;
						next_ok = 1'b0;
						next_state = bse_pkg::BSE_H_IDLE; // [R9]
					end
				end
			end
			bse_pkg::BSE_H_SEND_CONF: begin
				if (tx_done)
					next_state = bse_pkg::BSE_H_GET_CACK;
			end
			bse_pkg::BSE_H_GET_CACK: begin
				if (rx_take) begin
					next_result = rx;
					if (rx == `BSE_CONF_ERASE) begin
						next_state = bse_pkg::BSE_H_GET_RESULT;
					end else begin
						next_done = 1'b1;
						next_ok = 1'b0;
						next_state = bse_pkg::BSE_H_IDLE;
					end
				end
			end
			bse_pkg::BSE_H_GET_RESULT: begin
				if (rx_take) begin
					next_result = rx;
					next_done = 1'b1;
					next_ok = (rx == `BSE_RES_OK);
					next_state = bse_pkg::BSE_H_IDLE;
				end
			end
			bse_pkg::BSE_H_GET_INFO: begin
				if (rx_take) begin
					next_info_valid = 1'b1;
					next_info_data = rx;
					next_sum = 8'(sum + rx);
					next_cnt = 7'(cnt + 7'd1);
					if (cnt == `BSE_INFO_SUM) begin
						next_done = 1'b1;
						next_ok = (8'(sum + rx) == 8'h00); // [R6]
						next_result = rx;
						next_state = bse_pkg::BSE_H_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state <= bse_pkg::BSE_H_IDLE;
			linked <= 1'b0;
			clocked <= 1'b0;
			is_info <= 1'b0;
			wait_cnt <= 64'h0;
			cnt <= 7'h00;
			sum <= 8'h00;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			tx_err <= 1'b0;
			done <= 1'b0;
			ok <= 1'b0;
			result <= 8'h00;
			info_valid <= 1'b0;
			info_data <= 8'h00;
			busy <= 1'b0;
			link.d2h_ready <= 1'b0;
			link.h2d_slow <= 1'b0;
		end else begin
			state <= next_state;
			linked <= next_linked;
			clocked <= next_clocked;
			is_info <= next_is_info;
			wait_cnt <= next_wait_cnt;
			cnt <= next_cnt;
			sum <= next_sum;
			tx_valid <= next_tx_valid;
			tx_data <= next_tx_data;
			tx_err <= next_tx_err;
			done <= next_done;
			ok <= next_ok;
			result <= next_result;
			info_valid <= next_info_valid;
			info_data <= next_info_data;
			busy <= (next_state != bse_pkg::BSE_H_IDLE);
			link.d2h_ready <= rx_ready && !rx_take;
			// First two bytes of a clocked session run at the slow rate
			link.h2d_slow <= next_clocked && // [R8]
				(next_state == bse_pkg::BSE_H_SEND_MODE ||
				next_state == bse_pkg::BSE_H_GET_ECHO);
		end
	end

	assign link.h2d_valid = tx_valid;
	assign link.h2d_data = tx_data;
	assign link.h2d_err = tx_err;
endmodule : bse_host
`default_nettype wire

// ==== test/bse_link_assertions.sv ====
// Concurrent checks on the byte link between host and device
`timescale 1ns/10ps
`default_nettype none
module bse_link_assertions (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Host to device
	input wire logic h2d_valid,
	input wire bse_pkg::bse_byte_t h2d_data,
	input wire logic h2d_err,
	input wire logic h2d_slow,
	input wire logic h2d_ready,
	// Device to host
	input wire logic d2h_valid,
	input wire bse_pkg::bse_byte_t d2h_data,
	input wire logic d2h_ready
);
	// Large variant bytes 83 to 92, byte 83 in the low lane
	localparam logic [79:0] TAIL = 80'h03_00_01_00_00_3f_82_00_00_01;
	logic mode_seen, clocked, info_arm, info_on, conf_on;
	logic [6:0] info_cnt;
	bse_pkg::bse_byte_t last_in, last_cmd, info_sum;
	wire take = h2d_valid && h2d_ready;
	wire xfer = d2h_valid && d2h_ready;
	wire async_err = h2d_err && !clocked;
	wire good_cmd = take && mode_seen && !async_err;
	wire info_end = xfer && info_on && info_cnt == 7'h58;
	wire [6:0] tail_idx = info_cnt - 7'h4e;
	wire [7:0] tail_exp = TAIL[{tail_idx, 3'h0} +: 8];

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			{mode_seen, clocked, info_arm, info_on, conf_on} <= 5'h00;
			{last_in, last_cmd, info_sum, info_cnt} <= 31'h0;
		end else begin
			if (take) last_in <= h2d_data;
			if (take && !mode_seen) mode_seen <= 1'h1;
			if (take && !mode_seen) clocked <= h2d_data == 8'h30;
			if (good_cmd) last_cmd <= h2d_data;
			if (good_cmd) info_arm <= h2d_data == 8'h30;
			if (xfer) conf_on <= !conf_on && d2h_data == 8'h54 && last_cmd == 8'h54;
			if (xfer && info_arm) begin
				info_arm <= 1'h0;
				info_on <= 1'h1;
				{info_cnt, info_sum} <= 15'h0;
			end else if (xfer && info_on) begin
				info_cnt <= info_cnt + 7'h1;
				info_sum <= info_sum + d2h_data;
				if (info_end) info_on <= 1'h0;
			end
		end
	end

	chk_echo_mode: assert property (
		take && !mode_seen |-> ##[1:3] (d2h_valid && d2h_data == last_in))
		else $error("mode byte not echoed");
	chk_erase_ack: assert property (
		good_cmd && h2d_data == 8'h40 |-> ##[1:3] (d2h_valid && d2h_data == 8'h40))
		else $error("erase request not acknowledged");
	chk_conf_ack: assert property (
		good_cmd && last_cmd == 8'h40 && h2d_data == 8'h54
		|-> ##[1:3] (d2h_valid && d2h_data == 8'h54))
		else $error("erase confirm not acknowledged");
	chk_err_nibble: assert property (
		take && mode_seen && async_err |-> ##[1:3] (d2h_valid && d2h_data[3:0] == 4'h8))
		else $error("receive error not answered with error code");
	chk_err_upper: assert property (
		take && mode_seen && async_err
		|-> ##[1:3] (d2h_valid && d2h_data[7:4] == last_cmd[7:4]))
		else $error("error answer upper nibble wrong");
	chk_clocked_err: assert property (
		take && mode_seen && clocked && h2d_err && h2d_data == 8'h40
		|-> ##[1:3] (d2h_valid && d2h_data == 8'h40))
		else $error("clocked session reported a receive error");
	chk_info_tail: assert property (
		xfer && info_on && info_cnt >= 7'h4e && info_cnt <= 7'h57 |-> d2h_data == tail_exp)
		else $error("block group field byte wrong");
	chk_info_sum: assert property (
		info_end |-> d2h_data == 8'h00 - info_sum)
		else $error("checksum byte wrong");
	chk_erase_result: assert property (
		d2h_valid && conf_on |-> d2h_data == 8'h4f || d2h_data == 8'h4c)
		else $error("erase result code wrong");
	chk_back_to_cmd: assert property (
		info_end || (xfer && conf_on) |-> ##[1:4] h2d_ready)
		else $error("device did not return to command wait");

	cov_info_done: cover property (info_end);
	cov_err_nak: cover property (take && mode_seen && async_err);
	cov_result: cover property (xfer && conf_on);
endmodule : bse_link_assertions
`default_nettype wire

// ==== test/tb_boot_serial_info_and_erase.sv ====
// Bench for host and device ends joined by the byte link
`timescale 1ns/10ps
`default_nettype none
module tb_boot_serial_info_and_erase;
	typedef struct packed {logic inf, err, eok, exp_ok; logic [7:0] res;} bse_row_s;
	// Small variant bytes 83 to 92, byte 83 in the low lane
	localparam logic [79:0] SMALL_TAIL = 80'h00_00_01_00_00_00_00_00_00_01;
	logic sys_clk = 1'h0, reset = 1'h1, start = 1'h0, op_info = 1'h0;
	logic use_clocked = 1'h0, inject_err = 1'h0, erase_done = 1'h0;
	logic erase_ok = 1'h1, rate_ok2 = 1'h1, slow_seen = 1'h0;
	logic busy, done, ok, info_valid, erase_start, sec_bit;
	logic [7:0] result, info_data;
	logic [31:0] flash_id = 32'h1357_9bdf;
	int bad_count = 0, checks_done = 0, cycles = 0, info_n = 0;
	bse_pkg::bse_byte_t info_sum, rx, sum2, buf2 [0:88];
	bse_row_s rows [0:4] = '{'{1'h0, 1'h0, 1'h1, 1'h1, 8'h4f},
		'{1'h0, 1'h0, 1'h0, 1'h0, 8'h4c}, '{1'h1, 1'h0, 1'h1, 1'h1, 8'h00},
		'{1'h0, 1'h1, 1'h1, 1'h0, 8'h38}, '{1'h0, 1'h0, 1'h1, 1'h1, 8'h4f}};

	bse_link_if link (.sys_clk(sys_clk));
	bse_link_if link2 (.sys_clk(sys_clk));
	bse_host #(.ECHO_TIMEOUT_CYC(64'hc8)) bse_host_i (.sys_clk(sys_clk),
		.reset(reset), .link(link.host), .start(start), .op_info(op_info),
		.use_clocked(use_clocked), .inject_err(inject_err), .busy(busy),
		.done(done), .ok(ok), .result(result), .info_valid(info_valid),
		.info_data(info_data));
	bse_device bse_device_i (.sys_clk(sys_clk), .reset(reset), .link(link.dev),
		.rate_ok(1'h1), .flash_id(flash_id), .erase_start(erase_start),
		.erase_done(erase_done), .erase_ok(erase_ok), .sec_bit(sec_bit));
	// Second device faces the bench, which plays a misbehaving host
	bse_device #(.SMALL_VARIANT(1'h1)) bse_device_i2 (.sys_clk(sys_clk),
		.reset(reset), .link(link2.dev), .rate_ok(rate_ok2), .flash_id(flash_id),
		.erase_start(), .erase_done(1'h0), .erase_ok(1'h0), .sec_bit());
	bse_link_assertions bse_link_assertions_i (.sys_clk(sys_clk), .reset(reset),
		.h2d_valid(link.h2d_valid), .h2d_data(link.h2d_data),
		.h2d_err(link.h2d_err), .h2d_slow(link.h2d_slow),
		.h2d_ready(link.h2d_ready), .d2h_valid(link.d2h_valid),
		.d2h_data(link.d2h_data), .d2h_ready(link.d2h_ready));

	initial forever #2 sys_clk = ~sys_clk;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task close_out;
		$display("Counts: %0d checks, %0d mismatches", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			bad_count++;
			close_out();
		end
	end

	// Erase engine stand-in: finishes a few cycles after each start
	always @(negedge sys_clk) begin
		if (erase_start) begin
			repeat (6) @(negedge sys_clk);
			erase_done = 1'h1;
			@(negedge sys_clk);
			erase_done = 1'h0;
		end
	end

	always @(posedge sys_clk) begin
		if (reset)
			slow_seen <= 1'h0;
		else if (link.h2d_valid && link.h2d_ready && !slow_seen) begin
			slow_seen <= 1'h1;
			check(8'(link.h2d_slow), 8'(use_clocked));
			check(link.h2d_data, use_clocked ? 8'h30 : 8'h86);
		end
	end

	task automatic run(input logic inf, clk, err, eok);
		int n = 0;
		@(negedge sys_clk);
		{op_info, use_clocked, inject_err, erase_ok, start} = {inf, clk, err, eok, 1'h1};
		info_n = 0;
		info_sum = 8'h00;
		@(negedge sys_clk);
		start = 1'h0;
		check(8'(busy), 8'h01);
		while (done !== 1'h1 && n < 3000) begin
			@(negedge sys_clk);
			n++;
			// Counted in this loop so the byte seen with done is not raced
			if (info_valid) begin
				info_n++;
				info_sum += info_data;
			end
		end
		check(8'(done), 8'h01);
	endtask : run

	task automatic send2(input bse_pkg::bse_byte_t b, input logic e);
		int n = 0;
		{link2.h2d_valid, link2.h2d_data, link2.h2d_err} = {1'h1, b, e};
		while (link2.h2d_ready !== 1'h1 && n < 200) begin
			@(negedge sys_clk);
			n++;
		end
		@(negedge sys_clk);
		{link2.h2d_valid, link2.h2d_data, link2.h2d_err} = {1'h0, ~b, 1'h0};
	endtask : send2

	task automatic recv2(output bse_pkg::bse_byte_t b);
		int n = 0;
		link2.d2h_ready = 1'h1;
		while (link2.d2h_valid !== 1'h1 && n < 500) begin
			@(negedge sys_clk);
			n++;
		end
		b = link2.d2h_data;
		@(negedge sys_clk);
	endtask : recv2

	task automatic xchg2(input bse_pkg::bse_byte_t b, e, exp);
		send2(b, e[0]);
		recv2(rx);
		check(rx, exp);
	endtask : xchg2

	initial begin
		{link2.h2d_valid, link2.h2d_data, link2.h2d_err} = 10'h0;
		{link2.h2d_slow, link2.d2h_ready} = 2'h0;
		repeat (20) @(negedge sys_clk);
		reset = 1'h0;
		check(8'(sec_bit), 8'h00);
		foreach (rows[i]) begin
			run(rows[i].inf, 1'h0, rows[i].err, rows[i].eok);
			check(8'(ok), 8'(rows[i].exp_ok));
			if (!rows[i].inf)
				check(result, rows[i].res);
			else
				check(8'(info_n), 8'h59);
			if (rows[i].inf)
				check(info_sum, 8'h00);
			check(8'(sec_bit), 8'h01);
			$display("Row %0d done", i);
		end
		xchg2(8'h86, 8'h0, 8'h86);
		xchg2(8'h40, 8'h0, 8'h40);
		xchg2(8'h54, 8'h1, 8'h48);
		xchg2(8'h40, 8'h0, 8'h40);
		xchg2(8'h55, 8'h0, 8'h51);
		xchg2(8'h20, 8'h0, 8'h21);
		xchg2(8'h30, 8'h0, 8'h30);
		link2.d2h_ready = 1'h0;
		repeat (12) @(negedge sys_clk);
		check(8'({link2.h2d_ready, link2.d2h_valid}), 8'h01);
		check(link2.d2h_data, flash_id[7:0]);
		sum2 = 8'h00;
		for (int i = 0; i < 89; i++) begin
			recv2(buf2[i]);
			sum2 += buf2[i];
		end
		for (int i = 0; i < 4; i++)
			check(buf2[i], flash_id[8 * i +: 8]);
		for (int i = 0; i < 10; i++)
			check(buf2[78 + i], SMALL_TAIL[8 * i +: 8]);
		check(sum2, 8'h00);
		xchg2(8'h40, 8'h0, 8'h40);
		$display("Second device faults done");
		@(negedge sys_clk);
		{reset, rate_ok2} = 2'h2;
		repeat (20) @(negedge sys_clk);
		reset = 1'h0;
		check(8'(sec_bit), 8'h00);
		send2(8'h86, 1'h0);
		run(1'h0, 1'h1, 1'h1, 1'h1);
		check(8'(ok), 8'h01);
		check(result, 8'h4f);
		check(8'({link2.h2d_ready, link2.d2h_valid}), 8'h00);
		$display("Clocked session and bad rate done");
		close_out();
	end
endmodule : tb_boot_serial_info_and_erase
`default_nettype wire
